// file: bcd_counters_map.vh
`ifndef BCD_COUNTERS_MAP_VH
`define BCD_COUNTERS_MAP_VH

// ----------------------------------------------------------------
// bus and storage widths
// ----------------------------------------------------------------
`define ADDR_W        6
`define BUS_W         32
`define WORD_W        16
`define DM_AW         4
`define DM_DEPTH      16
`define CTRL_W        8

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      6'h00
`define OFS_EXEC      6'h04
`define OFS_DN_SV     6'h08
`define OFS_UD_SV     6'h0C
`define OFS_DN_PTR    6'h10
`define OFS_UD_PTR    6'h14
`define OFS_STATUS    6'h18
`define OFS_DN_PV     6'h1C
`define OFS_UD_PV     6'h20
`define OFS_DM_ADDR   6'h24
`define OFS_DM_DATA   6'h28

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define CTRL_CP       0
`define CTRL_DN_RST   1
`define CTRL_INC      2
`define CTRL_DEC      3
`define CTRL_UD_RST   4
`define CTRL_ILOCK    5
`define CTRL_DN_IND   6
`define CTRL_UD_IND   7
`define EXEC_GO       0
`define ST_DN_DONE    0
`define ST_UD_DONE    1
`define ST_ERR        2
`define ST_BUSY       3

// ----------------------------------------------------------------
// reset values and bcd constants
// ----------------------------------------------------------------
`define CTRL_RST      8'h00
`define WORD_ZERO     16'h0000
`define BUS_ZERO      32'h0000_0000
`define DIGIT_ZERO    4'h0
`define DIGIT_ONE     4'h1
`define DIGIT_FIVE    4'h5
`define DIGIT_NINE    4'h9
`define DIGIT_TEN     4'hA
`define PH_IDLE       2'h0
`define PH_FETCH      2'h1
`define PH_DONE       2'h2

`endif

// file: bcd_step.v
// ----------------------------------------------------------------
// four-digit bcd increment and decrement
// ----------------------------------------------------------------
`include "bcd_counters_map.vh"

module bcd_step (
  input  wire [`WORD_W-1:0] value_i,
  output wire [`WORD_W-1:0] inc_o,
  output wire [`WORD_W-1:0] dec_o
);

  wire [4:0] carry;
  wire [4:0] borrow;

  assign carry[0]  = 1'b1;
  assign borrow[0] = 1'b1;

  genvar d;
  generate
    for (d = 0; d < 4; d = d + 1)
    begin : digit
      wire [3:0] dig;
      assign dig = value_i[4*d+3:4*d];
      // carry out of a nine, borrow out of a zero
      assign carry[d+1]  = carry[d] & (dig == `DIGIT_NINE); // [RQ21]
      assign borrow[d+1] = borrow[d] & (dig == `DIGIT_ZERO); // [RQ21]
      assign inc_o[4*d+3:4*d] = !carry[d] ? dig :
                                (dig == `DIGIT_NINE) ? `DIGIT_ZERO : dig + `DIGIT_ONE;
      assign dec_o[4*d+3:4*d] = !borrow[d] ? dig :
                                (dig == `DIGIT_ZERO) ? `DIGIT_NINE : dig - `DIGIT_ONE;
    end
  endgenerate

endmodule

// file: dm_mem.v
// ----------------------------------------------------------------
// data memory for indirect set values
// ----------------------------------------------------------------
`include "bcd_counters_map.vh"

module dm_mem (
  input  wire               clk_i,
  input  wire               we_i,
  input  wire [`DM_AW-1:0]  addr_i,
  input  wire [`WORD_W-1:0] wdata_i,
  output reg  [`WORD_W-1:0] rdata_o
);

  reg [`WORD_W-1:0] mem [0:`DM_DEPTH-1];

  // read data registered every cycle
  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule

// file: bcd_counters.v
// Overview of operation
// [RQ1] down counter decrements on count pulse rise
// [RQ2] no change when pulse steady or falling
// [RQ3] done flag at zero until reset
// [RQ4] reset rise loads set value
// [RQ5] no counting while reset on
// [RQ6] value kept through interlock and power loss; nrst_i clears it to zero
// [RQ7] bad bcd set value flags, keeps running
// [RQ8] bad indirect word raises error flag
// [RQ9] four bcd digits, cascade for more
// [RQ10] program uses each counter number once
// [RQ11] reversible counter circles zero to set value
// [RQ12] increment rise adds one
// [RQ13] decrement rise subtracts one
// [RQ14] both rises leave value unchanged
// [RQ15] decrement from zero wraps, flag set
// [RQ16] increment past set value wraps, flag set
// [RQ17] reset rise clears, no counting meanwhile
// [RQ18] reversible value kept through interlock, power; nrst_i clears it to zero
// [RQ19] program avoids fastest clock pulse bits
// [RQ20] edge levels stored per execution
// [RQ21] four digits with digit carry and borrow
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`include "bcd_counters_map.vh"

module bcd_counters (
  input  wire               clk_i,
  input  wire               nrst_i,
  input  wire [`ADDR_W-1:0] address_i,
  input  wire               read_i,
  input  wire               write_i,
  input  wire [3:0]         byteenable_i,
  input  wire [`BUS_W-1:0]  writedata_i,
  output wire [`BUS_W-1:0]  readdata_o,
  output wire               waitrequest_o,
  output wire               down_done_o,
  output wire               updown_done_o,
  output wire               error_flag_o
);

  // ----------------------------------------------------------------
  // states of one execution
  // ----------------------------------------------------------------
  localparam S_IDLE    = 3'b000;
  localparam S_FETCH_D = 3'b001;
  localparam S_LOAD_D  = 3'b010;
  localparam S_FETCH_U = 3'b011;
  localparam S_LOAD_U  = 3'b100;
  localparam S_EXEC    = 3'b101;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function is_bcd;
    input [`WORD_W-1:0] w;
    begin
      is_bcd = (w[3:0] <= `DIGIT_NINE) && (w[7:4] <= `DIGIT_NINE) &&
               (w[11:8] <= `DIGIT_NINE) && (w[15:12] <= `DIGIT_NINE);
    end
  endfunction

  // pointer is bcd and names an existing word
  function ptr_ok;
    input [`WORD_W-1:0] p;
    begin
      ptr_ok = is_bcd(p) && (p[15:8] == 8'h00) &&
               ((p[7:4] == `DIGIT_ZERO) ||
                ((p[7:4] == `DIGIT_ONE) && (p[3:0] <= `DIGIT_FIVE)));
    end
  endfunction

  function [`DM_AW-1:0] ptr_idx;
    input [`WORD_W-1:0] p;
    begin
      ptr_idx = (p[7:4] == `DIGIT_ONE) ? p[3:0] + `DIGIT_TEN : p[3:0];
    end
  endfunction

  // byte-lane merge into a 16-bit word
  function [`WORD_W-1:0] merge;
    input [`WORD_W-1:0] old;
    input [`BUS_W-1:0]  wd;
    input [3:0]         be;
    begin
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [`CTRL_W-1:0] ctrl_reg;
  reg  [`WORD_W-1:0] dn_sv_reg;
  reg  [`WORD_W-1:0] ud_sv_reg;
  reg  [`WORD_W-1:0] dn_ptr_reg;
  reg  [`WORD_W-1:0] ud_ptr_reg;
  reg  [`DM_AW-1:0]  dm_addr_reg;
  reg  [`WORD_W-1:0] dn_pv_reg;
  reg  [`WORD_W-1:0] ud_pv_reg;
  reg  [`WORD_W-1:0] dn_sv_eff_reg;
  reg  [`WORD_W-1:0] ud_sv_eff_reg;
  reg                dn_done_reg;
  reg                ud_done_reg;
  reg                err_reg;
  reg                err_next;
  reg                cp_prev_reg;
  reg                dn_rst_prev_reg;
  reg                inc_prev_reg;
  reg                dec_prev_reg;
  reg                ud_rst_prev_reg;
  reg                exec_pend_reg;
  reg  [2:0]         state_reg;
  reg  [1:0]         phase_reg;
  reg  [`BUS_W-1:0]  readdata_reg;
  reg  [`BUS_W-1:0]  rd_mux;

  wire               req;
  wire               bus_go;
  wire               wr_now;
  wire [`DM_AW-1:0]  mem_addr;
  wire               mem_we;
  wire [`WORD_W-1:0] mem_rdata;
  wire [`WORD_W-1:0] dn_inc;
  wire [`WORD_W-1:0] dn_dec;
  wire [`WORD_W-1:0] ud_inc;
  wire [`WORD_W-1:0] ud_dec;
  wire               cp_rise;
  wire               dn_rst_rise;
  wire               inc_rise;
  wire               dec_rise;
  wire               ud_rst_rise;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign req           = read_i | write_i;
  assign bus_go        = req && (phase_reg == `PH_IDLE) &&
                         (state_reg == S_IDLE) && !exec_pend_reg;
  assign waitrequest_o = req && (phase_reg != `PH_DONE);
  assign wr_now        = write_i && (phase_reg == `PH_DONE);
  assign readdata_o    = readdata_reg;

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      phase_reg <= `PH_IDLE;
    end
    else
    begin
      case (phase_reg)
        `PH_IDLE:  phase_reg <= bus_go ? `PH_FETCH : `PH_IDLE;
        `PH_FETCH: phase_reg <= `PH_DONE;
        default:   phase_reg <= `PH_IDLE;
      endcase
    end
  end

  always @*
  begin
    rd_mux = `BUS_ZERO;
    case (address_i)
      `OFS_CTRL:    rd_mux[`CTRL_W-1:0] = ctrl_reg;
      `OFS_EXEC:    rd_mux[`EXEC_GO] = exec_pend_reg;
      `OFS_DN_SV:   rd_mux[`WORD_W-1:0] = dn_sv_reg;
      `OFS_UD_SV:   rd_mux[`WORD_W-1:0] = ud_sv_reg;
      `OFS_DN_PTR:  rd_mux[`WORD_W-1:0] = dn_ptr_reg;
      `OFS_UD_PTR:  rd_mux[`WORD_W-1:0] = ud_ptr_reg;
      `OFS_STATUS:
      begin
        rd_mux[`ST_DN_DONE] = dn_done_reg;
        rd_mux[`ST_UD_DONE] = ud_done_reg;
        rd_mux[`ST_ERR]     = err_reg;
        rd_mux[`ST_BUSY]    = exec_pend_reg | (state_reg != S_IDLE);
      end
      `OFS_DN_PV:   rd_mux[`WORD_W-1:0] = dn_pv_reg;
      `OFS_UD_PV:   rd_mux[`WORD_W-1:0] = ud_pv_reg;
      `OFS_DM_ADDR: rd_mux[`DM_AW-1:0] = dm_addr_reg;
      `OFS_DM_DATA: rd_mux[`WORD_W-1:0] = mem_rdata;
      default:      rd_mux = `BUS_ZERO;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      readdata_reg <= `BUS_ZERO;
    end
    else if (phase_reg == `PH_FETCH)
    begin
      readdata_reg <= read_i ? rd_mux : `BUS_ZERO;
    end
  end

  // software registers, byte lanes 0 and 1
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ctrl_reg    <= `CTRL_RST;
      dn_sv_reg   <= `WORD_ZERO;
      ud_sv_reg   <= `WORD_ZERO;
      dn_ptr_reg  <= `WORD_ZERO;
      ud_ptr_reg  <= `WORD_ZERO;
      dm_addr_reg <= {`DM_AW{1'b0}};
    end
    else if (wr_now)
    begin
      case (address_i)
        `OFS_CTRL:
        begin
          if (byteenable_i[0])
          begin
            ctrl_reg <= writedata_i[`CTRL_W-1:0];
          end
        end
        `OFS_DN_SV:   dn_sv_reg <= merge(dn_sv_reg, writedata_i, byteenable_i);
        `OFS_UD_SV:   ud_sv_reg <= merge(ud_sv_reg, writedata_i, byteenable_i);
        `OFS_DN_PTR:  dn_ptr_reg <= merge(dn_ptr_reg, writedata_i, byteenable_i);
        `OFS_UD_PTR:  ud_ptr_reg <= merge(ud_ptr_reg, writedata_i, byteenable_i);
        `OFS_DM_ADDR:
        begin
          if (byteenable_i[0])
          begin
            dm_addr_reg <= writedata_i[`DM_AW-1:0];
          end
        end
        default:      dm_addr_reg <= dm_addr_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data memory and bcd arithmetic
  // ----------------------------------------------------------------
  assign mem_addr = (state_reg == S_FETCH_D) ? ptr_idx(dn_ptr_reg) :
                    (state_reg == S_FETCH_U) ? ptr_idx(ud_ptr_reg) : dm_addr_reg;
  assign mem_we   = wr_now && (address_i == `OFS_DM_DATA) && (&byteenable_i[1:0]);

  dm_mem u_dm (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (writedata_i[`WORD_W-1:0]),
    .rdata_o (mem_rdata)
  );

  bcd_step u_dn_step (
    .value_i (dn_pv_reg),
    .inc_o   (dn_inc),
    .dec_o   (dn_dec)
  );

  bcd_step u_ud_step (
    .value_i (ud_pv_reg),
    .inc_o   (ud_inc),
    .dec_o   (ud_dec)
  );

  // ----------------------------------------------------------------
  // execution sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      exec_pend_reg <= 1'b0;
    end
    else if (wr_now && (address_i == `OFS_EXEC) && byteenable_i[0] &&
             writedata_i[`EXEC_GO])
    begin
      exec_pend_reg <= 1'b1;
    end
    else if ((state_reg == S_IDLE) && (phase_reg == `PH_IDLE))
    begin
      exec_pend_reg <= 1'b0;
    end
  end

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= S_IDLE;
    end
    else
    begin
      case (state_reg)
        S_IDLE:    state_reg <= (exec_pend_reg && (phase_reg == `PH_IDLE)) ?
                                S_FETCH_D : S_IDLE;
        S_FETCH_D: state_reg <= S_LOAD_D;
        S_LOAD_D:  state_reg <= S_FETCH_U;
        S_FETCH_U: state_reg <= S_LOAD_U;
        S_LOAD_U:  state_reg <= S_EXEC;
        default:   state_reg <= S_IDLE;
      endcase
    end
  end

  // effective set values and error checks
  always @*
  begin
    err_next = err_reg;
    case (state_reg)
      S_FETCH_D: err_next = 1'b0;
      S_LOAD_D:
      begin
        if (ctrl_reg[`CTRL_DN_IND])
        begin
          err_next = err_reg | !ptr_ok(dn_ptr_reg) | !is_bcd(mem_rdata); // [RQ8]
        end
        else
        begin
          err_next = err_reg | !is_bcd(dn_sv_reg); // [RQ7]
        end
      end
      S_LOAD_U:
      begin
        if (ctrl_reg[`CTRL_UD_IND])
        begin
          err_next = err_reg | !ptr_ok(ud_ptr_reg) | !is_bcd(mem_rdata); // [RQ8]
        end
        else
        begin
          err_next = err_reg | !is_bcd(ud_sv_reg); // [RQ7]
        end
      end
      default:   err_next = err_reg;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      err_reg       <= 1'b0;
      dn_sv_eff_reg <= `WORD_ZERO;
      ud_sv_eff_reg <= `WORD_ZERO;
    end
    else
    begin
      err_reg <= err_next;
      if (state_reg == S_LOAD_D)
      begin
        // a faulty set value is still used as read
        dn_sv_eff_reg <= ctrl_reg[`CTRL_DN_IND] ? mem_rdata : dn_sv_reg; // [RQ7]
      end
      if (state_reg == S_LOAD_U)
      begin
        ud_sv_eff_reg <= ctrl_reg[`CTRL_UD_IND] ? mem_rdata : ud_sv_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // counters, evaluated once per execution
  // ----------------------------------------------------------------
  assign cp_rise     = ctrl_reg[`CTRL_CP] & !cp_prev_reg; // [RQ1]
  assign dn_rst_rise = ctrl_reg[`CTRL_DN_RST] & !dn_rst_prev_reg; // [RQ4]
  assign inc_rise    = ctrl_reg[`CTRL_INC] & !inc_prev_reg; // [RQ12]
  assign dec_rise    = ctrl_reg[`CTRL_DEC] & !dec_prev_reg; // [RQ13]
  assign ud_rst_rise = ctrl_reg[`CTRL_UD_RST] & !ud_rst_prev_reg; // [RQ17]

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cp_prev_reg     <= 1'b0;
      dn_rst_prev_reg <= 1'b0;
      inc_prev_reg    <= 1'b0;
      dec_prev_reg    <= 1'b0;
      ud_rst_prev_reg <= 1'b0;
      dn_pv_reg       <= `WORD_ZERO;
      ud_pv_reg       <= `WORD_ZERO;
      dn_done_reg     <= 1'b0;
      ud_done_reg     <= 1'b0;
    end
    // interlock holds counter values, done flags and edge levels unchanged; the error flag is still re-evaluated
    else if ((state_reg == S_EXEC) && !ctrl_reg[`CTRL_ILOCK]) // [RQ6] [RQ18]
    begin
      cp_prev_reg     <= ctrl_reg[`CTRL_CP]; // [RQ20]
      dn_rst_prev_reg <= ctrl_reg[`CTRL_DN_RST]; // [RQ20]
      inc_prev_reg    <= ctrl_reg[`CTRL_INC]; // [RQ20]
      dec_prev_reg    <= ctrl_reg[`CTRL_DEC]; // [RQ20]
      ud_rst_prev_reg <= ctrl_reg[`CTRL_UD_RST]; // [RQ20]

      // down counter
      if (ctrl_reg[`CTRL_DN_RST])
      begin
        if (dn_rst_rise)
        begin
          dn_pv_reg <= dn_sv_eff_reg; // [RQ4]
        end
        dn_done_reg <= 1'b0; // [RQ5]
      end
      else if (cp_rise && (dn_pv_reg != `WORD_ZERO))
      begin
        dn_pv_reg <= dn_dec; // [RQ1] [RQ9]
        dn_done_reg <= (dn_dec == `WORD_ZERO); // [RQ3]
      end
      else
      begin
        dn_done_reg <= dn_done_reg | (dn_pv_reg == `WORD_ZERO); // [RQ2] [RQ3]
      end

      // reversible counter
      if (ctrl_reg[`CTRL_UD_RST])
      begin
        if (ud_rst_rise)
        begin
          ud_pv_reg   <= `WORD_ZERO; // [RQ17]
          ud_done_reg <= 1'b0;
        end
      end
      else if (inc_rise && !dec_rise)
      begin
        if (ud_pv_reg >= ud_sv_eff_reg)
        begin
          ud_pv_reg   <= `WORD_ZERO; // [RQ16] [RQ11]
          ud_done_reg <= 1'b1; // [RQ16]
        end
        else
        begin
          ud_pv_reg   <= ud_inc; // [RQ12] [RQ21]
          ud_done_reg <= 1'b0;
        end
      end
      else if (dec_rise && !inc_rise)
      begin
        if (ud_pv_reg == `WORD_ZERO)
        begin
          ud_pv_reg   <= ud_sv_eff_reg; // [RQ15] [RQ11]
          ud_done_reg <= 1'b1; // [RQ15]
        end
        else
        begin
          ud_pv_reg   <= ud_dec; // [RQ13] [RQ21]
          ud_done_reg <= 1'b0;
        end
      end
      else
      begin
        ud_pv_reg <= ud_pv_reg; // [RQ14]
      end
    end
  end

  // ----------------------------------------------------------------
  // flag outputs
  // ----------------------------------------------------------------
  assign down_done_o   = dn_done_reg;
  assign updown_done_o = ud_done_reg;
  assign error_flag_o  = err_reg;

endmodule

// file: bcd_counters_asserts.sv
`include "bcd_counters_map.vh"
module bcd_counters_asserts (
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire logic [`ADDR_W-1:0] address_i,
  input wire logic               read_i,
  input wire logic               write_i,
  input wire logic [3:0]         byteenable_i,
  input wire logic [`BUS_W-1:0]  writedata_i,
  input wire logic [`BUS_W-1:0]  readdata_o,
  input wire logic               waitrequest_o,
  input wire logic               down_done_o,
  input wire logic               updown_done_o,
  input wire logic               error_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [7:0] ctrl_seen;
  logic [5:0] since_go;
  wire        wr_ok = write_i && !waitrequest_o;
  wire        rd_ok = read_i && !waitrequest_o;
  wire [2:0]  flags = {error_flag_o, updown_done_o, down_done_o};
  function automatic logic bcd_ok(input logic [`BUS_W-1:0] v);
    return v[31:16] == 16'h0000 && v[15:12] <= 4'h9 && v[11:8] <= 4'h9
           && v[7:4] <= 4'h9 && v[3:0] <= 4'h9;
  endfunction
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ctrl_seen <= 8'h00;
      since_go  <= 6'h3F;
    end
    else
    begin
      if (wr_ok && address_i == `OFS_CTRL)
        ctrl_seen <= writedata_i[7:0];
      if (wr_ok && address_i == `OFS_EXEC && writedata_i[0])
        since_go <= 6'h00;
      else if (since_go != 6'h3F)
        since_go <= since_go + 6'h01;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_dn_pv_bcd: assert property (
    rd_ok && address_i == `OFS_DN_PV && !error_flag_o |-> bcd_ok(readdata_o))
    else $error("down value not four bcd digits");
  a_ud_pv_bcd: assert property (
    rd_ok && address_i == `OFS_UD_PV && !error_flag_o |-> bcd_ok(readdata_o))
    else $error("reversible value not four bcd digits");
  a_status_mirror: assert property (
    rd_ok && address_i == `OFS_STATUS |-> readdata_o[2:0] == flags)
    else $error("status bits differ from flag ports");
  a_flag_after_go: assert property (
    $changed(flags) |-> since_go >= 6'h01 && since_go <= 6'h14)
    else $error("flags moved outside an execution");
  a_ilock_frozen: assert property (
    $changed(flags) |-> !ctrl_seen[`CTRL_ILOCK])
    else $error("flags moved under interlock");
  a_dn_done_fall: assert property (
    $fell(down_done_o) |-> ctrl_seen[`CTRL_DN_RST])
    else $error("down done dropped without reset");
  a_dn_done_rise: assert property (
    $rose(down_done_o) |-> !ctrl_seen[`CTRL_DN_RST])
    else $error("down done rose while reset on");
  a_ud_done_rise: assert property (
    $rose(updown_done_o) |-> !ctrl_seen[`CTRL_UD_RST]
      && (ctrl_seen[`CTRL_INC] || ctrl_seen[`CTRL_DEC]))
    else $error("reversible done rose without a count");
  a_ud_done_fall: assert property (
    $fell(updown_done_o) |-> ctrl_seen[`CTRL_UD_RST]
      || ctrl_seen[`CTRL_INC] || ctrl_seen[`CTRL_DEC])
    else $error("reversible done dropped without a count");
endmodule

bind bcd_counters bcd_counters_asserts chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .down_done_o(down_done_o),
  .updown_done_o(updown_done_o), .error_flag_o(error_flag_o)
);

// file: ladder_scan.sv
`include "bcd_counters_map.vh"
module ladder_scan (
  input  wire logic               clk_i,
  input  wire logic [`BUS_W-1:0]  readdata_i,
  input  wire logic               waitrequest_i,
  output logic      [`ADDR_W-1:0] address_o,
  output logic                    read_o,
  output logic                    write_o,
  output logic      [3:0]         byteenable_o,
  output logic      [`BUS_W-1:0]  writedata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    read_o       = 1'b0;
    write_o      = 1'b0;
    byteenable_o = 4'hF;
  end
  // ----------------------------------------
  // bus cycles, held until waitrequest low
  // ----------------------------------------
  task automatic access(input logic wr, input logic [`ADDR_W-1:0] a,
                        input logic [`BUS_W-1:0] d, input logic [3:0] be,
                        output logic [`BUS_W-1:0] q);
    @(posedge clk_i);
    address_o    <= a;
    writedata_o  <= d;
    byteenable_o <= be;
    write_o     <= wr;
    read_o      <= !wr;
    @(posedge clk_i);
    while (waitrequest_i !== 1'b0)
      @(posedge clk_i);
    q = readdata_i;
    write_o <= 1'b0;
    read_o  <= 1'b0;
  endtask
  task automatic put(input logic [`ADDR_W-1:0] a, input logic [`BUS_W-1:0] d);
    logic [`BUS_W-1:0] q;
    access(1'b1, a, d, 4'hF, q);
  endtask
  task automatic get(input logic [`ADDR_W-1:0] a, output logic [`BUS_W-1:0] q);
    access(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask
  // ----------------------------------------
  // one scan: conditions, execute, wait idle
  // ----------------------------------------
  // one counter of each kind, one number each
  task automatic scan(input logic [7:0] c);
    logic [`BUS_W-1:0] q;
    put(`OFS_CTRL, {24'h000000, c});
    put(`OFS_EXEC, 32'h0000_0001);
    q = 32'h0000_0008;
    while (q[`ST_BUSY] !== 1'b0)
      get(`OFS_STATUS, q);
  endtask
endmodule

// file: test_bcd_counters.sv
`include "bcd_counters_map.vh"
module test_bcd_counters;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  c;
    logic [15:0] dn;
    logic [15:0] up;
    logic [2:0]  fl;
  } row_t;
  logic               clk_i;
  logic               nrst_i;
  wire [`ADDR_W-1:0]  address;
  wire                read;
  wire                write;
  wire [3:0]          byteenable;
  wire [`BUS_W-1:0]   writedata;
  wire [`BUS_W-1:0]   readdata;
  wire                waitrequest;
  wire                down_done;
  wire                updown_done;
  wire                error_flag;
  int                 fail_count;
  int                 cmp_count;
  int                 cycles;
  logic [`BUS_W-1:0]  q;
  row_t               rows [33];
  logic [15:0]        ptrs [3];
  bcd_counters dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .address_i(address), .read_i(read), .write_i(write),
    .byteenable_i(byteenable), .writedata_i(writedata), .readdata_o(readdata),
    .waitrequest_o(waitrequest), .down_done_o(down_done), .updown_done_o(updown_done),
    .error_flag_o(error_flag)
  );
  ladder_scan prog (
    .clk_i(clk_i), .readdata_i(readdata), .waitrequest_i(waitrequest),
    .address_o(address), .read_o(read), .write_o(write),
    .byteenable_o(byteenable), .writedata_o(writedata)
  );
  // ----------------------------------------
  // clock, timeout, checking
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] fl();
    return {29'h0, error_flag, updown_done, down_done};
  endfunction
  // ----------------------------------------
  // scans: ctrl, down pv, reversible pv, flags
  // ----------------------------------------
  initial
  begin
    rows = '{'{8'h12,16'h3,16'h0,3'h0}, '{8'h00,16'h3,16'h0,3'h0}, '{8'h01,16'h2,16'h0,3'h0},
      '{8'h01,16'h2,16'h0,3'h0}, '{8'h00,16'h2,16'h0,3'h0}, '{8'h05,16'h1,16'h1,3'h0},
      '{8'h00,16'h1,16'h1,3'h0}, '{8'h05,16'h0,16'h2,3'h1}, '{8'h00,16'h0,16'h2,3'h1},
      '{8'h05,16'h0,16'h0,3'h3}, '{8'h00,16'h0,16'h0,3'h3}, '{8'h04,16'h0,16'h1,3'h1},
      '{8'h00,16'h0,16'h1,3'h1}, '{8'h08,16'h0,16'h0,3'h1}, '{8'h00,16'h0,16'h0,3'h1},
      '{8'h08,16'h0,16'h2,3'h3}, '{8'h00,16'h0,16'h2,3'h3}, '{8'h0C,16'h0,16'h2,3'h3},
      '{8'h00,16'h0,16'h2,3'h3}, '{8'h08,16'h0,16'h1,3'h1}, '{8'h03,16'h3,16'h1,3'h0},
      '{8'h02,16'h3,16'h1,3'h0}, '{8'h03,16'h3,16'h1,3'h0}, '{8'h01,16'h3,16'h1,3'h0},
      '{8'h00,16'h3,16'h1,3'h0}, '{8'h01,16'h2,16'h1,3'h0}, '{8'h14,16'h2,16'h0,3'h0},
      '{8'h10,16'h2,16'h0,3'h0}, '{8'h14,16'h2,16'h0,3'h0}, '{8'h00,16'h2,16'h0,3'h0},
      '{8'h04,16'h2,16'h1,3'h0}, '{8'h21,16'h2,16'h1,3'h0}, '{8'h01,16'h1,16'h1,3'h0}};
    ptrs = '{16'h0016, 16'h001A, 16'h0005};
    fail_count = 0;
    cmp_count = 0;
    cycles = 0;
    nrst_i = 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    prog.put(`OFS_DN_SV, 32'h3);
    prog.put(`OFS_UD_SV, 32'h2);
    foreach (rows[i])
    begin
      prog.scan(rows[i].c);
      prog.get(`OFS_DN_PV, q);
      check(q, {16'h0, rows[i].dn});
      prog.get(`OFS_UD_PV, q);
      check(q, {16'h0, rows[i].up});
      check(fl(), {29'h0, rows[i].fl});
    end
    $display("test table done");
    prog.put(`OFS_DN_SV, 32'h00A5);
    prog.scan(8'h02);
    check(fl(), 32'h4);
    prog.get(`OFS_DN_PV, q);
    check(q, 32'h00A5);
    $display("test bad set value done");
    prog.put(`OFS_DN_SV, 32'h1000);
    prog.put(`OFS_UD_SV, 32'h9999);
    prog.scan(8'h00);
    prog.scan(8'h12);
    prog.scan(8'h09);
    prog.get(`OFS_DN_PV, q);
    check(q, 32'h0999);
    prog.get(`OFS_UD_PV, q);
    check(q, 32'h9999);
    check(fl(), 32'h2);
    prog.scan(8'h00);
    prog.scan(8'h04);
    prog.get(`OFS_UD_PV, q);
    check(q, 32'h0000);
    $display("test digits done");
    prog.put(`OFS_DM_ADDR, 32'h5);
    prog.put(`OFS_DM_DATA, 32'h0004);
    prog.put(`OFS_DN_PTR, 32'h0005);
    prog.scan(8'h42);
    prog.get(`OFS_DN_PV, q);
    check(q, 32'h0004);
    check(fl(), 32'h2);
    prog.put(`OFS_DM_DATA, 32'h00F0);
    foreach (ptrs[i])
    begin
      prog.put(`OFS_DN_PTR, {16'h0, ptrs[i]});
      prog.scan(8'h40);
      check(fl(), 32'h6);
    end
    $display("test indirect done");
    prog.get(`OFS_CTRL, q);
    check(q, 32'h40);
    prog.get(`OFS_DN_SV, q);
    check(q, 32'h1000);
    prog.access(1'b1, `OFS_DN_SV, 32'h0077, 4'h1, q);
    prog.get(`OFS_DN_SV, q);
    check(q, 32'h1077);
    prog.access(1'b1, `OFS_DM_DATA, 32'h0003, 4'h1, q);
    prog.get(`OFS_DM_DATA, q);
    check(q, 32'h00F0);
    prog.put(6'h3C, 32'hFFFF);
    prog.get(6'h3C, q);
    check(q, 32'h0);
    prog.put(`OFS_STATUS, 32'h0);
    prog.get(`OFS_STATUS, q);
    check(q, 32'h6);
    $display("test registers done");
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    prog.get(`OFS_DN_PV, q);
    check(q, 32'h0);
    prog.get(`OFS_UD_PV, q);
    check(q, 32'h0);
    check(fl(), 32'h0);
    $display("test reset done");
    give_verdict();
  end
endmodule
